/* logic/cctf_pkg.sv */
// cctf_pkg: register map, field positions and carrier types for the
// can control / timer / filter slice.
// assumes a 32-bit register port with byte offsets.
package cctf_pkg;

   // register offsets (byte addresses)
   localparam logic [7:0]  CCTF_OFF_CTRL2   = 8'h04;
   localparam logic [7:0]  CCTF_OFF_TIMER   = 8'h08;
   localparam logic [7:0]  CCTF_OFF_FILTER  = 8'h10;

   // reset values
   localparam logic [31:0] CCTF_CTRL2_RST   = 32'h0000_0000;
   localparam logic [15:0] CCTF_TIMER_RST   = 16'h0000;
   localparam logic [31:0] CCTF_FILTER_RST  = 32'h0000_0000;

   // field positions of can_control_two
   localparam int CCTF_B_BUSOFF_IE = 15;
   localparam int CCTF_B_ERRSUM_IE = 14;
   localparam int CCTF_B_LBSIL     = 12;
   localparam int CCTF_B_TXWARN_IE = 11;
   localparam int CCTF_B_RXWARN_IE = 10;
   localparam int CCTF_B_TRIPLE    = 7;
   localparam int CCTF_B_NOAUTOREC = 6;
   localparam int CCTF_B_TIME_SYNC_ENABLE     = 5;
   localparam int CCTF_B_TXORDER   = 4;
   localparam int CCTF_B_MONITOR   = 3;

   // writable bit masks
   localparam logic [31:0] CCTF_CTRL2_RW_MASK  = 32'h0000_DCF8;
   localparam logic [31:0] CCTF_CTRL2_INA_MASK = 32'h0000_10B8;
   localparam logic [31:0] CCTF_CTRL2_WRN_MASK = 32'h0000_0C00;

   // filter mask fields
   localparam int CCTF_F_RTR   = 31;
   localparam int CCTF_F_IDE   = 30;
   localparam int CCTF_ID_W    = 29;

   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } cctf_req_s;

   // configuration handed to the protocol engine
   typedef struct packed {
      logic triple_sampling_select;
      logic auto_recovery_disable;
      logic time_sync_enable;
      logic tx_order_select;
      logic listen_monitor_enable;
      logic loopback_silent_select;
   } cctf_cfg_s;

   // mailbox descriptor fields to compare
   typedef struct packed {
      logic                rtr;
      logic                ide;
      logic [CCTF_ID_W-1:0] id;
   } cctf_mbx_s;

endpackage : cctf_pkg

/* logic/cctf_stamp_timer.sv */
// cctf_stamp_timer: 16-bit free-running timestamp counter with load.
// assumes the protocol engine supplies one tick per bit time.
`timescale 1ns/1ps
module cctf_stamp_timer
   import cctf_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        tick,
   input  wire logic        sync_clear,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   output logic [15:0]      count
);

   logic [15:0] count_r;
   logic [15:0] count_nxt;

   // software load wins, then sync clear, then counting
   assign count_nxt = load       ? load_val :
                      sync_clear ? CCTF_TIMER_RST :
                      tick       ? 16'(count_r + 16'h0001) : count_r;

   // counter storage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) count_r <= CCTF_TIMER_RST;
      else     count_r <= count_nxt;
   end

   assign count = count_r;

endmodule // cctf_stamp_timer

/* logic/cctf_mask_match.sv */
// cctf_mask_match: compares a received frame with a mailbox descriptor
// under the public filter mask.
// assumes all inputs are stable levels.
`timescale 1ns/1ps
module cctf_mask_match
   import cctf_pkg::*;
(
   input  wire logic [31:0] mask,
   input  wire cctf_mbx_s   frame,
   input  wire cctf_mbx_s   mbx,
   output logic             hit
);

   logic [31:0] diff;
   logic [31:0] care;

   // per-bit compare; a 1 in the mask means the bit is checked
   assign diff = {frame.rtr ^ mbx.rtr, frame.ide ^ mbx.ide, 1'b0, frame.id ^ mbx.id};
   assign care = {mask[CCTF_F_RTR], mask[CCTF_F_IDE], 1'b0, mask[CCTF_ID_W-1:0]};
   assign hit  = ~|(diff & care);

endmodule // cctf_mask_match

/* logic/cctf_ctrl_regs.sv */
// cctf_ctrl_regs: second control register, timestamp counter and public
// rx filter mask of a can fd controller, with interrupt gating.
// assumes a one-cycle register port and level status from the engine.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module cctf_ctrl_regs
   import cctf_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // state from the main control register and error logic
   input  wire logic        inactive_mode,
   input  wire logic        warning_enable,
   input  wire logic        soft_reset_request,
   input  wire logic        self_reception_disable_req,
   input  wire logic        tx_delay_comp_enable_req,
   input  wire logic        tx_warning_status,
   input  wire logic        rx_warning_status,
   input  wire logic        tx_warning_clear,
   input  wire logic        rx_warning_clear,
   input  wire logic        busoff_flag,
   input  wire logic        error_summary_flag,
   input  wire logic        time_tick,
   input  wire logic        time_sync_event,
   // filter compare
   input  wire cctf_mbx_s   rx_frame,
   input  wire cctf_mbx_s   mbx_desc,
   output logic             filter_hit,
   // outputs to the rest of the controller
   output cctf_cfg_s        cfg,
   output logic             self_reception_disable,
   output logic             tx_delay_comp_enable,
   output logic             tx_warning_irq_flag,
   output logic             rx_warning_irq_flag,
   output logic             busoff_irq,
   output logic             error_summary_irq,
   output logic             tx_warning_irq,
   output logic             rx_warning_irq,
   output logic [15:0]      timestamp_counter
);

   logic [31:0] ctrl2_r;
   logic [31:0] ctrl2_nxt;
   logic [31:0] filter_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        txw_flag_r;
   logic        rxw_flag_r;
   logic        txw_stat_r;
   logic        rxw_stat_r;
   logic [31:0] wr_allow;
   logic [31:0] ctrl2_view;
   logic        sel_ctrl2;
   logic        sel_timer;
   logic        sel_filter;
   logic        txw_rise;
   logic        rxw_rise;

   // address decode
   assign sel_ctrl2  = (reg_addr == CCTF_OFF_CTRL2);
   assign sel_timer  = (reg_addr == CCTF_OFF_TIMER);
   assign sel_filter = (reg_addr == CCTF_OFF_FILTER);

   // per-bit write permission of control two; blocked bits keep value
   assign wr_allow = CCTF_CTRL2_RW_MASK
                   & ~(inactive_mode  ? 32'h0000_0000 : CCTF_CTRL2_INA_MASK)
                   & ~(warning_enable ? 32'h0000_0000 : CCTF_CTRL2_WRN_MASK);

   // soft reset request is not an input to this update at all
   assign ctrl2_nxt = (reg_wr && sel_ctrl2) ?
                      ((reg_wdata & wr_allow) | (ctrl2_r & ~wr_allow)) : ctrl2_r;

   // control two storage; only the asynchronous reset clears it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) ctrl2_r <= CCTF_CTRL2_RST;
      else     ctrl2_r <= ctrl2_nxt;
   end

   // filter mask storage, written only in inactive mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) filter_r <= CCTF_FILTER_RST;
      else if (reg_wr && sel_filter && inactive_mode) filter_r <= reg_wdata;
   end

   // warning enables read as zero while warning enable is clear
   assign ctrl2_view = ctrl2_r & ~(warning_enable ? 32'h0000_0000 : CCTF_CTRL2_WRN_MASK);

   // read mux, registered for next-cycle data; unmapped reads zero
   assign rdata_nxt = !reg_rd    ? 32'h0000_0000 :
                      sel_ctrl2  ? ctrl2_view :
                      sel_timer  ? {16'h0000, timestamp_counter} :
                      sel_filter ? filter_r : 32'h0000_0000;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) rdata_r <= 32'h0000_0000;
      else     rdata_r <= rdata_nxt;
   end
   assign reg_rdata = rdata_r;

   // timestamp counter, loadable by a word write
   cctf_stamp_timer u_timer (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .tick       (time_tick),
      .sync_clear (time_sync_event & ctrl2_r[CCTF_B_TIME_SYNC_ENABLE]),
      .load       (reg_wr && sel_timer),
      .load_val   (reg_wdata[15:0]),
      .count      (timestamp_counter)
   );

   // mailbox filter compare
   cctf_mask_match u_match (
      .mask  (filter_r),
      .frame (rx_frame),
      .mbx   (mbx_desc),
      .hit   (filter_hit)
   );

   // warning status edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txw_stat_r <= 1'b0;
         rxw_stat_r <= 1'b0;
      end else begin
         txw_stat_r <= tx_warning_status;
         rxw_stat_r <= rx_warning_status;
      end
   end
   assign txw_rise = tx_warning_status & ~txw_stat_r & warning_enable;
   assign rxw_rise = rx_warning_status & ~rxw_stat_r & warning_enable;

   // sticky warning flags; a new edge wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txw_flag_r <= 1'b0;
         rxw_flag_r <= 1'b0;
      end else begin
         txw_flag_r <= txw_rise | (txw_flag_r & ~tx_warning_clear);
         rxw_flag_r <= rxw_rise | (rxw_flag_r & ~rx_warning_clear);
      end
   end
   assign tx_warning_irq_flag = txw_flag_r;
   assign rx_warning_irq_flag = rxw_flag_r;

   // interrupt gating
   assign busoff_irq        = ctrl2_r[CCTF_B_BUSOFF_IE] & busoff_flag;
   assign error_summary_irq = ctrl2_r[CCTF_B_ERRSUM_IE] & error_summary_flag;
   assign tx_warning_irq    = ctrl2_view[CCTF_B_TXWARN_IE] & txw_flag_r;
   assign rx_warning_irq    = ctrl2_view[CCTF_B_RXWARN_IE] & rxw_flag_r;

   // mode outputs
   assign cfg.loopback_silent_select = ctrl2_r[CCTF_B_LBSIL];
   assign cfg.triple_sampling_select = ctrl2_r[CCTF_B_TRIPLE];
   assign cfg.auto_recovery_disable  = ctrl2_r[CCTF_B_NOAUTOREC];
   assign cfg.time_sync_enable       = ctrl2_r[CCTF_B_TIME_SYNC_ENABLE];
   assign cfg.tx_order_select        = ctrl2_r[CCTF_B_TXORDER];
   assign cfg.listen_monitor_enable  = ctrl2_r[CCTF_B_MONITOR];

   // loopback-silent holds these two off
   assign self_reception_disable = self_reception_disable_req & ~ctrl2_r[CCTF_B_LBSIL];
   assign tx_delay_comp_enable   = tx_delay_comp_enable_req & ~ctrl2_r[CCTF_B_LBSIL];

   // assertions
   AST_INA_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel_ctrl2 && !inactive_mode) |=>
      ((ctrl2_r & CCTF_CTRL2_INA_MASK) == ($past(ctrl2_r) & CCTF_CTRL2_INA_MASK)))
      else $error("inactive-only bit changed outside inactive mode");
   AST_SOFT_RST: assert property (@(posedge sys_clk) disable iff (rst)
      (soft_reset_request && !(reg_wr && sel_ctrl2)) |=> $stable(ctrl2_r))
      else $error("control two changed on soft reset");
   AST_BUSOFF_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      busoff_irq == (ctrl2_r[15] && busoff_flag))
      else $error("bus-off irq gating wrong");
   AST_ERRSUM_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      error_summary_irq == (ctrl2_r[14] && error_summary_flag))
      else $error("error summary irq gating wrong");
   AST_LBSIL: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.loopback_silent_select |-> !self_reception_disable && !tx_delay_comp_enable)
      else $error("blocked bit set in loopback-silent mode");
   AST_WARN_WR: assert property (@(posedge sys_clk) disable iff (rst)
      !warning_enable |=> ctrl2_r[11:10] == $past(ctrl2_r[11:10]))
      else $error("warning enable written while disabled");
   AST_WARN_RD: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && sel_ctrl2 && !warning_enable) |=> reg_rdata[11:10] == 2'b00)
      else $error("warning enables read nonzero");
   AST_FILTER_WR: assert property (@(posedge sys_clk) disable iff (rst)
      (!inactive_mode) |=> $stable(filter_r))
      else $error("filter mask changed outside inactive mode");
   AST_TXW_SET: assert property (@(posedge sys_clk) disable iff (rst)
      (warning_enable && tx_warning_status && !txw_stat_r) |=> txw_flag_r)
      else $error("tx warning flag missed a rising edge");
   AST_TIMER_RD: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && sel_timer) |=> reg_rdata == {16'h0000, $past(timestamp_counter)})
      else $error("timer read data wrong");

   // mode outputs follow their register bits; self reception disable follows its request outside loopback-silent
   AST_TRIPLE: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.triple_sampling_select == ctrl2_r[CCTF_B_TRIPLE])
      else $error("sampling select does not follow control two");
   AST_AUTOREC: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.auto_recovery_disable == ctrl2_r[CCTF_B_NOAUTOREC])
      else $error("recovery disable does not follow control two");
   AST_TXORDER: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.tx_order_select == ctrl2_r[CCTF_B_TXORDER])
      else $error("transmit order does not follow control two");
   AST_MONITOR: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.listen_monitor_enable == ctrl2_r[CCTF_B_MONITOR])
      else $error("monitor enable does not follow control two");
   AST_LBSIL_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg.loopback_silent_select |-> self_reception_disable == self_reception_disable_req)
      else $error("self reception disable held off outside loopback-silent");

   // register writes land whole when every gate is open; filter hit follows the masked compare
   AST_CTRL2_WR: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel_ctrl2 && inactive_mode && warning_enable) |=>
      ctrl2_r == ($past(reg_wdata) & CCTF_CTRL2_RW_MASK))
      else $error("open control two write did not land");
   AST_FILTER_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel_filter && inactive_mode) |=> filter_r == $past(reg_wdata))
      else $error("filter mask write in inactive mode did not land");
   AST_HIT: assert property (@(posedge sys_clk) disable iff (rst)
      filter_hit == ((({rx_frame.rtr, rx_frame.ide, rx_frame.id}
      ^ {mbx_desc.rtr, mbx_desc.ide, mbx_desc.id})
      & {filter_r[31], filter_r[30], filter_r[28:0]}) == 31'h0000_0000))
      else $error("filter hit wrong");

   // timestamp counter: load, tick and synchronised clear
   AST_TIMER_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel_timer) |=> timestamp_counter == $past(reg_wdata[15:0]))
      else $error("timer write did not load the counter");
   AST_TICK: assert property (@(posedge sys_clk) disable iff (rst)
      (time_tick && !time_sync_event && !(reg_wr && sel_timer)) |=>
      timestamp_counter == 16'($past(timestamp_counter) + 16'h0001))
      else $error("timer did not advance on a tick");
   AST_TIME_SYNC_ENABLE_CLR: assert property (@(posedge sys_clk) disable iff (rst)
      (time_sync_event && ctrl2_r[CCTF_B_TIME_SYNC_ENABLE] && !(reg_wr && sel_timer)) |=>
      timestamp_counter == 16'h0000)
      else $error("timer not cleared by sync event");
   AST_TIME_SYNC_ENABLE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      (time_sync_event && !ctrl2_r[CCTF_B_TIME_SYNC_ENABLE] && !time_tick && !(reg_wr && sel_timer))
      |=> $stable(timestamp_counter))
      else $error("timer changed on sync event while sync disabled");

   // warning flags follow status only while warning enable is set
   AST_RXW_SET: assert property (@(posedge sys_clk) disable iff (rst)
      (warning_enable && rx_warning_status && !rxw_stat_r) |=> rxw_flag_r)
      else $error("rx warning flag missed a rising edge");
   AST_NO_WARN: assert property (@(posedge sys_clk) disable iff (rst)
      (!warning_enable && !txw_flag_r) |=> !txw_flag_r)
      else $error("tx warning flag set while warning enable clear");
   AST_TXW_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      (txw_flag_r && !tx_warning_clear) |=> txw_flag_r)
      else $error("tx warning flag dropped without a clear");
   AST_RXW_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      (rxw_flag_r && !rx_warning_clear) |=> rxw_flag_r)
      else $error("rx warning flag dropped without a clear");

   // warning requests need both the enable bit and the flag
   AST_WARN_IRQ_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      !warning_enable |-> (!tx_warning_irq && !rx_warning_irq))
      else $error("warning irq raised while warning enable clear");
   AST_TXW_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      !txw_flag_r |-> !tx_warning_irq)
      else $error("tx warning irq without its flag");

   COV_LBSIL: cover property (@(posedge sys_clk) disable iff (rst) cfg.loopback_silent_select);
   COV_TXW_IRQ: cover property (@(posedge sys_clk) disable iff (rst) tx_warning_irq);
   COV_BLOCKED: cover property (@(posedge sys_clk) disable iff (rst)
      reg_wr && sel_ctrl2 && !inactive_mode);
   COV_HIT: cover property (@(posedge sys_clk) disable iff (rst) filter_hit && |filter_r);
   COV_SYNC_CLR: cover property (@(posedge sys_clk) disable iff (rst)
      time_sync_event && ctrl2_r[CCTF_B_TIME_SYNC_ENABLE]);

endmodule // cctf_ctrl_regs

/* test/cctf_engine_model.sv */
// cctf_engine_model: protocol engine stand-in for the control slice.
// assumes the bench asks for status levels and tick runs by level requests.
`timescale 1ns/1ps
module cctf_engine_model
   import cctf_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       tick_en,
   input  wire logic [3:0] status_req,
   output logic            time_tick,
   output logic            tx_warning_status,
   output logic            rx_warning_status,
   output logic            busoff_flag,
   output logic            error_summary_flag,
   output logic [15:0]     tick_count
);
   logic [1:0] div_r;
   // one tick every third cycle while running; status levels lag requests
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_r      <= 2'h0;
         time_tick  <= 1'b0;
         tick_count <= 16'h0000;
         {tx_warning_status, rx_warning_status, busoff_flag, error_summary_flag} <= 4'h0;
      end else begin
         div_r      <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
         time_tick  <= tick_en && (div_r == 2'h2);
         tick_count <= tick_count + {15'h0000, tick_en && (div_r == 2'h2)};
         {tx_warning_status, rx_warning_status, busoff_flag, error_summary_flag} <= status_req;
      end
   end
endmodule // cctf_engine_model

/* test/test_can_ctrl_timer_filter_regs.sv */
// test_can_ctrl_timer_filter_regs: self-checking bench for control two,
// timer and filter mask. assumes one 50 MHz clock and the engine model.
`timescale 1ns/1ps
module test_can_ctrl_timer_filter_regs
   import cctf_pkg::*;
;
   logic        sys_clk, rst, reg_wr, reg_rd, inactive_mode, warning_enable;
   logic        soft_reset_request, srd_req, tdc_req, tx_clr, rx_clr, sync_ev, tick_en;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, exp_c2, r, q, fm, seed;
   logic [3:0]  status_req;
   logic        time_tick, tx_st, rx_st, bo_flag, es_flag, filter_hit, srd, tdc;
   logic        tx_if, rx_if, bo_irq, es_irq, tx_irq, rx_irq;
   logic [15:0] ts_cnt, n_tick, base, tval;
   cctf_mbx_s   frame, mbx;
   cctf_cfg_s   cfg;
   int          failures, compares;

   cctf_ctrl_regs cctf_ctrl_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .inactive_mode(inactive_mode), .warning_enable(warning_enable),
      .soft_reset_request(soft_reset_request), .self_reception_disable_req(srd_req),
      .tx_delay_comp_enable_req(tdc_req), .tx_warning_status(tx_st),
      .rx_warning_status(rx_st), .tx_warning_clear(tx_clr), .rx_warning_clear(rx_clr),
      .busoff_flag(bo_flag), .error_summary_flag(es_flag), .time_tick(time_tick),
      .time_sync_event(sync_ev), .rx_frame(frame), .mbx_desc(mbx), .filter_hit(filter_hit),
      .cfg(cfg), .self_reception_disable(srd), .tx_delay_comp_enable(tdc),
      .tx_warning_irq_flag(tx_if), .rx_warning_irq_flag(rx_if), .busoff_irq(bo_irq),
      .error_summary_irq(es_irq), .tx_warning_irq(tx_irq), .rx_warning_irq(rx_irq),
      .timestamp_counter(ts_cnt));
   cctf_engine_model cctf_engine_model_inst (.sys_clk(sys_clk), .rst(rst), .tick_en(tick_en),
      .status_req(status_req), .time_tick(time_tick), .tx_warning_status(tx_st),
      .rx_warning_status(rx_st), .busoff_flag(bo_flag), .error_summary_flag(es_flag),
      .tick_count(n_tick));

   // free-running 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // compare one value and count
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      compares++;
      if (seen !== expv) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   // verdict and end of run
   task automatic wrap_up();
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one-cycle write, settled one step after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // one-cycle read, data checked in the following cycle
   task automatic rdchk(input logic [7:0] a, input logic [31:0] expv);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, expv);
   endtask
   // control two write with the bench's own copy following the mode gates
   task automatic wc2(input logic [31:0] d);
      q = 32'h0000_C040 | (inactive_mode ? CCTF_CTRL2_INA_MASK : 32'h0000_0000)
          | (warning_enable ? CCTF_CTRL2_WRN_MASK : 32'h0000_0000);
      wr(CCTF_OFF_CTRL2, d);
      exp_c2 = (exp_c2 & ~q) | (d & q);
   endtask
   // expected filter result: mask bit 1 compares, 0 ignores
   function automatic logic exp_hit(input logic [31:0] m, input cctf_mbx_s f, input cctf_mbx_s b);
      return (({m[31], m[30], m[28:0]} & (f ^ b)) == 31'h0000_0000);
   endfunction

   // main sequence
   initial begin
      seed = 32'hdff9a308;
      failures = 0;
      compares = 0;
      exp_c2 = 32'h0000_0000;
      {rst, reg_wr, reg_rd, inactive_mode, warning_enable, soft_reset_request} = 6'h20;
      {srd_req, tdc_req, tx_clr, rx_clr, sync_ev, tick_en} = 6'h00;
      {reg_addr, reg_wdata, status_req} = 44'h000_0000_0000;
      {frame, mbx} = 62'h0000_0000_0000_0000;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(CCTF_OFF_CTRL2, CCTF_CTRL2_RST);
      rdchk(CCTF_OFF_TIMER, 32'h0000_0000);
      rdchk(8'h0C, 32'h0000_0000);
      // random writes across modes, soft reset and status levels
      for (int i = 0; i < 60; i++) begin
         r = $random(seed);
         {inactive_mode, warning_enable, soft_reset_request} <= r[2:0];
         status_req <= r[7:4];
         @(posedge sys_clk);
         wc2($random(seed));
         rdchk(CCTF_OFF_CTRL2, exp_c2 & ~(warning_enable ? 32'h0 : CCTF_CTRL2_WRN_MASK));
         check({26'h0, cfg}, {26'h0, exp_c2[7:3], exp_c2[12]});
         check({30'h0, bo_irq, es_irq}, {30'h0, exp_c2[15] & bo_flag, exp_c2[14] & es_flag});
      end
      // loopback-silent holds back self reception disable and delay compensation
      inactive_mode <= 1'b1;
      {srd_req, tdc_req} <= 2'h3;
      @(posedge sys_clk);
      for (int k = 0; k < 2; k++) begin
         wc2((k == 0) ? 32'h0000_1000 : 32'h0000_0000);
         check({30'h0, srd, tdc}, (k == 0) ? 32'h0 : 32'h3);
      end
      // warning flags rise with status only while warning enable is set
      warning_enable <= 1'b1;
      status_req <= 4'h0;
      @(posedge sys_clk);
      wc2(32'h0000_0C00);
      for (int k = 0; k < 2; k++) begin
         {tx_clr, rx_clr} <= 2'h3;
         @(posedge sys_clk);
         {tx_clr, rx_clr} <= 2'h0;
         warning_enable <= (k == 0);
         status_req <= 4'h0;
         repeat (3) @(posedge sys_clk);
         status_req <= 4'hC;
         repeat (3) @(posedge sys_clk);
         #1 check({28'h0, tx_if, rx_if, tx_irq, rx_irq}, (k == 0) ? 32'hF : 32'h0);
         if (k == 0) wc2(32'h0000_0400);
         check({30'h0, tx_if, tx_irq}, (k == 0) ? 32'h2 : 32'h0);
      end
      // timer load, counting, then synchronised clear gated by bit 5
      wr(CCTF_OFF_TIMER, 32'h0000_BEEF);
      rdchk(CCTF_OFF_TIMER, 32'h0000_BEEF);
      base = n_tick;
      tick_en <= 1'b1;
      for (int w = 0; w < 200 && (n_tick - base) < 16'h0007; w++) @(posedge sys_clk);
      tick_en <= 1'b0;
      if ((n_tick - base) < 16'h0007) begin
         failures++;
         wrap_up();
      end
      repeat (4) @(posedge sys_clk);
      tval = 16'hBEEF + (n_tick - base);
      #1 check({16'h0, ts_cnt}, {16'h0, tval});
      for (int k = 0; k < 2; k++) begin
         wc2((k == 0) ? 32'h0000_0000 : 32'h0000_0020);
         sync_ev <= 1'b1;
         @(posedge sys_clk);
         sync_ev <= 1'b0;
         #1 check({16'h0, ts_cnt}, (k == 0) ? {16'h0, tval} : 32'h0);
      end
      // filter mask blocked outside inactive mode, then masked compares
      fm = $random(seed);
      wr(CCTF_OFF_FILTER, fm);
      inactive_mode <= 1'b0;
      wr(CCTF_OFF_FILTER, ~fm);
      rdchk(CCTF_OFF_FILTER, fm);
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         q = $random(seed) & $random(seed) & $random(seed) & $random(seed);
         frame <= cctf_mbx_s'(r[30:0]);
         mbx <= cctf_mbx_s'(r[30:0] ^ q[30:0]);
         @(posedge sys_clk);
         #1 check({31'h0, filter_hit}, {31'h0, exp_hit(fm, frame, mbx)});
      end
      wrap_up();
   end
endmodule // test_can_ctrl_timer_filter_regs
